// file: hw/backlight_level_current_pkg.sv
// Overview of operation
// R1 - Office max code in bits 6:0.
// R2 - Office dim code in bits 6:0.
// R3 - Dark max code in bits 6:0.
// R4 - Dark dim code in bits 6:0.
// R5 - Dim flag selects level's dim code.
// R6 - Code zero is 0 mA, full is 30 mA.
// R7 - Sink fade law in bits 1:0.
// R8 - Law 00: linear DAC, even steps.
// R9 - Law 01: square DAC, even steps.
// R10 - Law 10: square DAC, first cubic profile.
// R11 - Law 11: square DAC, second cubic profile.
// R12 - Dim timeout expiry also selects dim code.
// R13 - Reserved bits read zero, writes ignored.
package backlight_level_current_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CODE_W = 7;
   localparam int unsigned UA_W   = 15;

   localparam logic [7:0] OFFICE_MAX_CURRENT_OFS = 8'h0B;
   localparam logic [7:0] OFFICE_DIM_CURRENT_OFS = 8'h0C;
   localparam logic [7:0] DARK_MAX_CURRENT_OFS   = 8'h0D;
   localparam logic [7:0] DARK_DIM_CURRENT_OFS   = 8'h0E;
   localparam logic [7:0] SINK_FADE_LAW_CTRL_OFS = 8'h0F;

   localparam int unsigned CODE_LSB = 0;
   localparam int unsigned CODE_MSB = 6;
   localparam int unsigned LAW_LSB  = 0;
   localparam int unsigned LAW_MSB  = 1;

   localparam logic [6:0] CODE_RESET = 7'h00;
   localparam logic [1:0] LAW_RESET  = 2'h0;

   localparam logic [1:0] LAW_LINEAR   = 2'h0;
   localparam logic [1:0] LAW_SQUARE   = 2'h1;
   localparam logic [1:0] LAW_CUBIC_A  = 2'h2;
   localparam logic [1:0] LAW_CUBIC_B  = 2'h3;

   localparam int unsigned FULL_SCALE_UA = 30000;
   localparam int unsigned CODE_MAX      = 127;

   localparam int unsigned CLK_MHZ       = 50;
   localparam int unsigned FADE_STEP_US  = 40;
   localparam int unsigned FADE_STEP_CYC = FADE_STEP_US * CLK_MHZ;

   // Integer truncation keeps code 0 at zero and code 127 at exactly full scale.
   function automatic logic [14:0] code_to_ua(input logic [6:0] code, input logic square);
      logic [31:0] num;
      num = square ? (32'(code) * 32'(code) * 32'(FULL_SCALE_UA)) / 32'(CODE_MAX * CODE_MAX)
                   : (32'(code) * 32'(FULL_SCALE_UA)) / 32'(CODE_MAX);
      return num[14:0];
   endfunction

   // Step dwell multiplier; the two cubic profiles dwell longer at opposite ends.
   function automatic logic [2:0] step_weight(input logic [1:0] law, input logic [6:0] code);
      logic [2:0] w;
      w = 3'h1;
      if (law == LAW_CUBIC_A) begin
         w = 3'(code[6:5]) + 3'h1;
      end else if (law == LAW_CUBIC_B) begin
         w = 3'h4 - 3'(code[6:5]);
      end
      return w;
   endfunction

endpackage

// file: hw/sink_dac_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sink_dac_if;
   logic [6:0]  targetCode;
   logic [1:0]  fadeLaw;
   logic [6:0]  dacCode;
   logic [14:0] dacUa;
   logic        settled;
   modport owner   (output targetCode, output fadeLaw, input dacCode, input dacUa, input settled);
   modport stepper (input targetCode, input fadeLaw, output dacCode, output dacUa, output settled);
endinterface
`default_nettype wire

// file: hw/sink_fade_stepper.sv
`timescale 1ns/1ps
`default_nettype none
module sink_fade_stepper
   import backlight_level_current_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = FADE_STEP_CYC
) (
   input  wire logic    clk,
   input  wire logic    resetn,
   sink_dac_if.stepper  dac
);

   // The tick counter is 16 bits wide, so longer dwell times cannot be counted.
   if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_badStep
      $error("STEP_CYCLES out of range");
   end

   typedef enum logic {IDLE, FADE} fade_e;

   fade_e       state_q;
   logic [6:0]  code_q;
   logic [15:0] tick_q;
   logic [2:0]  weight_q;
   logic [14:0] ua_q;

   wire logic        atTarget = (code_q == dac.targetCode);
   wire logic        tickDone = (tick_q == 16'(STEP_CYCLES - 1));
   wire logic        stepNow  = tickDone && (weight_q <= 3'h1);
   wire logic [6:0]  nextCode = (code_q < dac.targetCode) ? code_q + 7'h01 : code_q - 7'h01;
   wire logic        squareDac = (dac.fadeLaw != LAW_LINEAR); // R8 R9 R10 R11

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q  <= IDLE;
         code_q   <= CODE_RESET;
         tick_q   <= 16'h0000;
         weight_q <= 3'h1;
      end else begin
         unique case (state_q)
            IDLE: begin
               tick_q <= 16'h0000;
               if (!atTarget) begin
                  state_q  <= FADE;
                  weight_q <= step_weight(dac.fadeLaw, code_q); // R10 R11
               end
            end
            FADE: begin
               tick_q <= tickDone ? 16'h0000 : tick_q + 16'h0001;
               if (atTarget) begin
                  state_q <= IDLE;
               end else if (stepNow) begin
                  code_q   <= nextCode;
                  weight_q <= step_weight(dac.fadeLaw, nextCode); // R10 R11
               end else if (tickDone) begin
                  weight_q <= weight_q - 3'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ua_q <= 15'h0000;
      end else begin
         ua_q <= code_to_ua(code_q, squareDac); // R6
      end
   end

   assign dac.dacCode = code_q;
   assign dac.dacUa   = ua_q;
   assign dac.settled = atTarget && (state_q == IDLE);

endmodule
`default_nettype wire

// file: hw/backlight_level_current_regs.sv
`timescale 1ns/1ps
`default_nettype none
module backlight_level_current_regs
   import backlight_level_current_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = FADE_STEP_CYC
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output var  logic [7:0]  regRdData,
   output var  logic        regRdValid,
   input  wire logic        ambientDark,
   input  wire logic        dimEnable,
   input  wire logic        dimTimeout,
   input  wire logic        backlightSquare,
   input  wire logic [6:0]  sinkTargetCode,
   output var  logic [6:0]  backlightCode,
   output var  logic [14:0] backlightUa,
   output var  logic        backlightDimmed,
   output var  logic [6:0]  sinkCode,
   output var  logic [14:0] sinkUa,
   output var  logic        sinkSettled
);

   logic [6:0] officeMaxCode_q;
   logic [6:0] officeDimCode_q;
   logic [6:0] darkMaxCode_q;
   logic [6:0] darkDimCode_q;
   logic [1:0] sinkFadeLaw_q;

   wire logic hitOfficeMax = (regAddr == OFFICE_MAX_CURRENT_OFS);
   wire logic hitOfficeDim = (regAddr == OFFICE_DIM_CURRENT_OFS);
   wire logic hitDarkMax   = (regAddr == DARK_MAX_CURRENT_OFS);
   wire logic hitDarkDim   = (regAddr == DARK_DIM_CURRENT_OFS);
   wire logic hitSinkLaw   = (regAddr == SINK_FADE_LAW_CTRL_OFS);

   // Only the code and law fields are stored, so reserved bits cannot hold state.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         officeMaxCode_q <= CODE_RESET;
         officeDimCode_q <= CODE_RESET;
         darkMaxCode_q   <= CODE_RESET;
         darkDimCode_q   <= CODE_RESET;
         sinkFadeLaw_q   <= LAW_RESET;
      end else if (regWrEn) begin
         if (hitOfficeMax) begin
            officeMaxCode_q <= regWrData[CODE_MSB:CODE_LSB]; // R1 R13
         end
         if (hitOfficeDim) begin
            officeDimCode_q <= regWrData[CODE_MSB:CODE_LSB]; // R2 R13
         end
         if (hitDarkMax) begin
            darkMaxCode_q <= regWrData[CODE_MSB:CODE_LSB]; // R3 R13
         end
         if (hitDarkDim) begin
            darkDimCode_q <= regWrData[CODE_MSB:CODE_LSB]; // R4 R13
         end
         if (hitSinkLaw) begin
            sinkFadeLaw_q <= regWrData[LAW_MSB:LAW_LSB]; // R7 R13
         end
      end
   end

   wire logic [7:0] rdMux =
      hitOfficeMax ? {1'b0, officeMaxCode_q} : // R1 R13
      hitOfficeDim ? {1'b0, officeDimCode_q} : // R2 R13
      hitDarkMax   ? {1'b0, darkMaxCode_q}   : // R3 R13
      hitDarkDim   ? {1'b0, darkDimCode_q}   : // R4 R13
      hitSinkLaw   ? {6'h00, sinkFadeLaw_q}  : // R7 R13
      8'h00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            regRdData <= rdMux;
         end
      end
   end

   // A timeout dims the panel even when software never asked for it.
   wire logic       dimActive = dimEnable || dimTimeout; // R5 R12
   wire logic [6:0] maxSel    = ambientDark ? darkMaxCode_q : officeMaxCode_q;
   wire logic [6:0] dimSel    = ambientDark ? darkDimCode_q : officeDimCode_q;
   wire logic [6:0] blSel     = dimActive ? dimSel : maxSel; // R5 R12

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         backlightCode   <= CODE_RESET;
         backlightUa     <= 15'h0000;
         backlightDimmed <= 1'b0;
      end else begin
         backlightCode   <= blSel;
         backlightUa     <= code_to_ua(blSel, backlightSquare); // R6
         backlightDimmed <= dimActive;
      end
   end

   sink_dac_if sinkDac ();

   assign sinkDac.targetCode = sinkTargetCode;
   assign sinkDac.fadeLaw    = sinkFadeLaw_q; // R8 R9 R10 R11

   sink_fade_stepper #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_stepper (
      .clk    (clk),
      .resetn (resetn),
      .dac    (sinkDac.stepper)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sinkCode    <= CODE_RESET;
         sinkUa      <= 15'h0000;
         sinkSettled <= 1'b1;
      end else begin
         sinkCode    <= sinkDac.dacCode;
         sinkUa      <= sinkDac.dacUa;
         sinkSettled <= sinkDac.settled;
      end
   end

endmodule
`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   output var  logic [7:0] regAddr,
   output var  logic [7:0] regWrData,
   output var  logic       regWrEn,
   output var  logic       regRdEn,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // Released lines show the inverse so a stale value can never pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      regWrData = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdValid ? regRdData : 8'hXX;
   endtask
endmodule
`default_nettype wire

// file: bench/backlight_level_current_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module backlight_level_current_asserts
   import backlight_level_current_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = FADE_STEP_CYC
) (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [7:0]  regAddr,
   input wire logic        regRdEn,
   input wire logic [7:0]  regRdData,
   input wire logic        regRdValid,
   input wire logic        dimEnable,
   input wire logic        dimTimeout,
   input wire logic [6:0]  backlightCode,
   input wire logic [14:0] backlightUa,
   input wire logic        backlightDimmed,
   input wire logic [6:0]  sinkCode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence unmapped_rd;
      regRdEn && (regAddr < 8'h0B || regAddr > 8'h0F);
   endsequence
   sequence sink_step;
      $changed(sinkCode);
   endsequence
   read_answer_a: assert property (regRdEn |=> regRdValid)
      else $error("read not answered");
   valid_cause_a: assert property (regRdValid |-> $past(regRdEn))
      else $error("stray read valid");
   unmapped_zero_a: assert property (unmapped_rd |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   reserved_bit_a: assert property (regRdValid |-> !regRdData[7])
      else $error("reserved bit seven set");
   law_bits_a: assert property (regRdEn && regAddr == 8'h0F |=> regRdData[7:2] == 6'h00)
      else $error("law reserved bits set");
   dim_follow_a: assert property ($past(resetn) |-> backlightDimmed == $past(dimEnable || dimTimeout))
      else $error("dim flag wrong");
   full_scale_a: assert property (backlightCode == 7'h7F |-> backlightUa == 15'h7530)
      else $error("full scale wrong");
   zero_code_a: assert property (backlightCode == 7'h00 |-> backlightUa == 15'h0000)
      else $error("zero code not zero");
   unit_step_a: assert property (sink_step |-> sinkCode == $past(sinkCode) + 7'h01 || sinkCode == $past(sinkCode) - 7'h01)
      else $error("sink jumped");
   step_dwell_a: assert property (sink_step |=> $stable(sinkCode) [*3])
      else $error("sink stepped early");
endmodule
bind backlight_level_current_regs backlight_level_current_asserts #(
   .STEP_CYCLES (STEP_CYCLES)
) chk_i (
   .clk             (clk),
   .resetn          (resetn),
   .regAddr         (regAddr),
   .regRdEn         (regRdEn),
   .regRdData       (regRdData),
   .regRdValid      (regRdValid),
   .dimEnable       (dimEnable),
   .dimTimeout      (dimTimeout),
   .backlightCode   (backlightCode),
   .backlightUa     (backlightUa),
   .backlightDimmed (backlightDimmed),
   .sinkCode        (sinkCode)
);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import backlight_level_current_pkg::*;
;
   logic        clk, resetn, regWrEn, regRdEn, regRdValid, ambientDark, dimEnable, dimTimeout;
   logic        backlightSquare, backlightDimmed, sinkSettled;
   logic [7:0]  regAddr, regWrData, regRdData, rd;
   logic [6:0]  sinkTargetCode, backlightCode, sinkCode, e;
   logic [14:0] backlightUa, sinkUa;
   int          err_total, checked, n, f, cv;
   backlight_level_current_regs #(
      .STEP_CYCLES (4)
   ) uut (
      .clk             (clk),
      .resetn          (resetn),
      .regAddr         (regAddr),
      .regWrData       (regWrData),
      .regWrEn         (regWrEn),
      .regRdEn         (regRdEn),
      .regRdData       (regRdData),
      .regRdValid      (regRdValid),
      .ambientDark     (ambientDark),
      .dimEnable       (dimEnable),
      .dimTimeout      (dimTimeout),
      .backlightSquare (backlightSquare),
      .sinkTargetCode  (sinkTargetCode),
      .backlightCode   (backlightCode),
      .backlightUa     (backlightUa),
      .backlightDimmed (backlightDimmed),
      .sinkCode        (sinkCode),
      .sinkUa          (sinkUa),
      .sinkSettled     (sinkSettled)
   );
   host_model host (
      .clk        (clk),
      .regAddr    (regAddr),
      .regWrData  (regWrData),
      .regWrEn    (regWrEn),
      .regRdEn    (regRdEn),
      .regRdData  (regRdData),
      .regRdValid (regRdValid)
   );
   always #10 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, x, g);
      end
   endtask
   task automatic print_verdict;
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wchg;
      logic [6:0] p;
      p = sinkCode;
      n = 0;
      while (sinkCode === p) begin
         @(negedge clk);
         n++;
         if (n > 200) begin
            err_total++;
            print_verdict();
         end
      end
   endtask
   // The first step also spends a cycle leaving idle, so the second step is timed instead.
   task automatic fade_to(input logic [6:0] t);
      sinkTargetCode = t;
      for (int k = 0; k < 128 && sinkCode !== t; k++) begin
         wchg();
         if (k == 0) chk("busy", 0, sinkSettled);
         if (k == 1) f = n;
      end
      repeat (4) @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      ambientDark = 1'b0;
      dimEnable = 1'b0;
      dimTimeout = 1'b0;
      backlightSquare = 1'b0;
      sinkTargetCode = 7'h00;
      err_total = 0;
      checked = 0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      for (int i = 0; i < 5; i++) begin
         host.wr(8'h0B + 8'(i), 8'hFF);
         host.rd(8'h0B + 8'(i), rd);
         chk("regread", (i == 4) ? 8'h03 : 8'h7F, rd);
      end
      host.wr(8'h10, 8'hAA);
      host.rd(8'h10, rd);
      chk("unmapped", 8'h00, rd);
      host.wr(OFFICE_MAX_CURRENT_OFS, 8'h91);
      host.wr(OFFICE_DIM_CURRENT_OFS, 8'h22);
      host.wr(DARK_MAX_CURRENT_OFS, 8'h33);
      host.wr(DARK_DIM_CURRENT_OFS, 8'hC4);
      for (int i = 0; i < 6; i++) begin
         ambientDark = i[0];
         dimEnable = (i[2:1] == 2'h1);
         dimTimeout = (i[2:1] == 2'h2);
         repeat (2) @(negedge clk);
         e = ambientDark ? (i[2:1] != 0 ? 7'h44 : 7'h33) : (i[2:1] != 0 ? 7'h22 : 7'h11);
         chk("blcode", e, backlightCode);
         chk("bldim", i[2:1] != 0, backlightDimmed);
      end
      dimEnable = 1'b0;
      dimTimeout = 1'b0;
      ambientDark = 1'b0;
      for (int i = 0; i < 6; i++) begin
         cv = (i < 2) ? 0 : (i < 4) ? 1 : 127;
         backlightSquare = i[0];
         host.wr(OFFICE_MAX_CURRENT_OFS, 8'(cv));
         repeat (2) @(negedge clk);
         chk("blua", i[0] ? cv * cv * 30000 / 16129 : cv * 30000 / 127, backlightUa);
      end
      for (int l = 0; l < 4; l++) begin
         host.wr(SINK_FADE_LAW_CTRL_OFS, 8'(l));
         fade_to(7'h62);
         chk("first", (l == 3) ? 16 : 4, f);
         chk("last", (l == 2) ? 16 : 4, n);
         chk("sinkua", (l == 0) ? 98 * 30000 / 127 : 98 * 98 * 30000 / 16129, sinkUa);
         chk("settled", 1, sinkSettled);
         fade_to(7'h00);
      end
      host.wr(OFFICE_MAX_CURRENT_OFS, 8'h55);
      repeat (2) @(negedge clk);
      resetn = 1'b0;
      @(negedge clk);
      chk("rstcode", 7'h00, backlightCode);
      chk("rstdone", 1, sinkSettled);
      resetn = 1'b1;
      host.rd(OFFICE_MAX_CURRENT_OFS, rd);
      chk("rstreg", 8'h00, rd);
      host.rd(SINK_FADE_LAW_CTRL_OFS, rd);
      chk("rstlaw", 8'h00, rd);
      print_verdict();
   end
endmodule
`default_nettype wire
